// >>> rtl/upc_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial control block
`ifndef UPC_REGS_SVH
`define UPC_REGS_SVH
// ====================
// Register offsets
`define UPC_OFS_CTL1 3'h0
`define UPC_OFS_CTL2 3'h1
`define UPC_OFS_STAT 3'h2
`define UPC_OFS_DATA 3'h3
`define UPC_OFS_AUX 3'h4
// ====================
// Control one fields
`define UPC_C1_LOOP 7
`define UPC_C1_EN 6
`define UPC_C1_INV 5
`define UPC_C1_LEN 4
`define UPC_C1_WAKE 3
`define UPC_C1_IDLE_COUNT_START_SELECT 2
`define UPC_C1_PEN 1
`define UPC_C1_PTY 0
// ====================
// Control two fields
`define UPC_C2_TEIE 7
`define UPC_C2_TX_DONE_IRQ_ENABLE 6
`define UPC_C2_RFIE 5
`define UPC_C2_IDLE_LINE_IRQ_ENABLE 4
`define UPC_C2_TE 3
`define UPC_C2_RE 2
`define UPC_C2_STBY 1
`define UPC_C2_SBK 0
// ====================
// Status fields
`define UPC_ST_TXE 7
`define UPC_ST_TC 6
`define UPC_ST_RXF 5
`define UPC_ST_IDLE 4
`define UPC_ST_FE 1
`define UPC_ST_PE 0
// ====================
// Reset values, frame lengths and bit timing
`define UPC_CTL_RST 8'h00
`define UPC_LEN_SHORT 4'hA
`define UPC_LEN_LONG 4'hB
`define UPC_BIT_CYCLES 16
`endif

// >>> rtl/upc_pkg.sv
// Types and shared frame helpers of the serial control block
`include "upc_regs.svh"
package upc_pkg;
  // ====================
  // Receiver states
  typedef enum logic [1:0] {
    UPC_RX_IDLE = 2'b00,
    UPC_RX_START = 2'b01,
    UPC_RX_DATA = 2'b10
  } upc_rx_e;

  // ====================
  // Parity bit for the data bits below the top data position
  function automatic logic upc_parity(input logic [8:0] d, input logic len, input logic odd);
    logic p;
    p = len ? ^d[7:0] : ^d[6:0];
    return p ^ odd;
  endfunction : upc_parity

  // Frame length in bits, start and stop included
  function automatic logic [3:0] upc_flen(input logic len);
    return len ? `UPC_LEN_LONG : `UPC_LEN_SHORT;
  endfunction : upc_flen
endpackage : upc_pkg

// >>> rtl/upc_tx.sv
// Transmit shifter: sends a frame vector LSB first, one bit per baud tick
module upc_tx
  import upc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic clr,
  input wire logic tick,
  input wire logic load,
  input wire logic [10:0] frame,
  input wire logic [3:0] nbits,
  // Status and line
  output logic ser,
  output logic busy,
  output logic last
);
  typedef struct packed {
    logic [10:0] sh;
    logic [3:0] left;
    logic busy;
  } upc_tx_s;

  upc_tx_s s_q;
  upc_tx_s s_d;

  // Idle shifter holds all ones so the line rests high
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.sh = 11'h7FF;
      s_d.left = 4'h0;
      s_d.busy = 1'b0;
    end else if (load) begin
      s_d.sh = frame;
      s_d.left = nbits;
      s_d.busy = 1'b1;
    end else if (tick && s_q.busy) begin
      s_d.sh = {1'b1, s_q.sh[10:1]};
      s_d.left = s_q.left - 4'h1;
      s_d.busy = (s_q.left != 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{sh: 11'h7FF, left: 4'h0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ser = s_q.sh[0];
  assign busy = s_q.busy;
  assign last = s_q.busy && (s_q.left == 4'h1);
endmodule : upc_tx

// >>> rtl/upc_rx.sv
// Receiver: mid-bit sampling of frames and counting of idle ones
`include "upc_regs.svh"
module upc_rx
  import upc_pkg::*;
#(
  parameter int unsigned DIV = `UPC_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic en,
  input wire logic line,
  input wire logic len,
  input wire logic idle_count_start_select,
  // Results
  output logic [8:0] data,
  output logic done,
  output logic ferr,
  output logic idle
);
  typedef struct packed {
    upc_rx_e st;
    logic [15:0] cnt;
    logic [3:0] left;
    logic [8:0] sh;
    logic [3:0] ones;
    logic done;
    logic ferr;
    logic idle;
  } upc_rx_s;

  localparam logic [15:0] FULL = 16'(DIV - 1);
  localparam logic [15:0] HALF = 16'(DIV / 2 - 1);
  upc_rx_s s_q;
  upc_rx_s s_d;

  // Frame sampling; the ones count pulses once when it reaches a frame length
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.idle = 1'b0;
    if (!en) begin
      s_d.st = UPC_RX_IDLE;
      s_d.cnt = 16'h0000;
      s_d.ones = 4'h0;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
      case (s_q.st)
        UPC_RX_IDLE: begin
          if (!line) begin
            s_d.st = UPC_RX_START;
            s_d.cnt = 16'h0000;
          end else if (s_q.cnt == FULL) begin
            s_d.cnt = 16'h0000;
            if (s_q.ones != upc_flen(len)) begin
              s_d.ones = s_q.ones + 4'h1;
              s_d.idle = (s_q.ones + 4'h1 == upc_flen(len));
            end
          end
        end
        UPC_RX_START: begin
          if (s_q.cnt == HALF) begin
            s_d.cnt = 16'h0000;
            s_d.st = line ? UPC_RX_IDLE : UPC_RX_DATA;
            s_d.left = upc_flen(len) - 4'h1;
            if (!line && !idle_count_start_select) begin
              s_d.ones = 4'h0; // R10
            end
          end
        end
        UPC_RX_DATA: begin
          if (s_q.cnt == FULL) begin
            s_d.cnt = 16'h0000;
            s_d.left = s_q.left - 4'h1;
            if (!idle_count_start_select) begin
              s_d.ones = line ? s_q.ones + 4'h1 : 4'h0; // R10
            end
            if (s_q.left == 4'h1) begin
              s_d.st = UPC_RX_IDLE;
              s_d.done = 1'b1;
              s_d.ferr = !line;
              if (idle_count_start_select) begin
                s_d.ones = 4'h0; // R10
              end
            end else begin
              s_d.sh = {line, s_q.sh[8:1]};
            end
          end
        end
        default: begin
          s_d.st = UPC_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data = len ? s_q.sh : {1'b0, s_q.sh[8:1]};
  assign done = s_q.done;
  assign ferr = s_q.ferr;
  assign idle = s_q.idle;
endmodule : upc_rx

// >>> rtl/upc_top.sv
// Serial transceiver control: registers, pin ownership, frame sequencing and flags
// Functional notes
// R1: Enabled module drives transmit pin as output
// R2: Enabled module takes receive pin as input
// R3: Loop select feeds transmitter into receiver
// R4: Loop mode needs both enables set
// R5: Module enable gates logic; clearing sets flags
// R6: Inversion bit inverts every transmitted level
// R7: Frames: start, 8 or 9 bits, stop
// R8: Parity in top data bit, odd/even
// R9: Wake by address mark or idle line
// R10: Idle count starts after start or stop
// R11: Do not change parity type mid-character
// R12: Transmit requests gated by their enable bits
// R13: Receive requests gated by their enable bits
// R14: Transmitter enable sends all-ones preamble first
// R15: Disabled transmitter finishes character, then idles
// R16: Enable toggle mid-character queues idle character
// R17: No enable writes while module disabled
// R18: Receiver enable gates reception, flags kept
// R19: Standby suppresses receive requests; wake clears it
// R20: Break then single one, or repeats
// R21: Break toggled early replaces the preamble
// R22: Reset clears both control registers
// R23: Empty flag: set on load, two-step clear
// R24: Complete flag while nothing queued or sent
// R25: Break is full frame of zeros
`include "upc_regs.svh"
module upc_top
  import upc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = `UPC_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Port logic sharing the pins
  input wire logic port_tx_data,
  input wire logic port_rx_data,
  input wire logic tx_pin_direction_bit,
  input wire logic rx_pin_direction_bit,
  // Transmit pin
  output logic port_pin_tx_out,
  output logic port_pin_tx_oe,
  // Receive pin
  input wire logic port_pin_rx_in,
  output logic port_pin_rx_out,
  output logic port_pin_rx_oe,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic txe;
    logic tc;
    logic rxf;
    logic idle;
    logic pe;
    logic fe;
    logic txe_arm;
    logic rx_arm;
    logic idle_arm;
    logic [7:0] tdr;
    logic t8;
    logic [8:0] rdr;
    logic pre_pend;
    logic brk_pend;
    logic one_pend;
    logic [15:0] bcnt;
    logic tick;
    logic [2:0] rsync;
    logic rline;
    logic [7:0] rdata;
  } upc_top_s;

  upc_top_s s_q;
  upc_top_s s_d;

  // ====================
  // Control bit views
  logic en, loop, inv, len, wake, idle_count_start_select, parity_enable, parity_type, te, re, stby, send_break;
  assign en = s_q.c1[`UPC_C1_EN];
  assign loop = s_q.c1[`UPC_C1_LOOP];
  assign inv = s_q.c1[`UPC_C1_INV];
  assign len = s_q.c1[`UPC_C1_LEN];
  assign wake = s_q.c1[`UPC_C1_WAKE];
  assign idle_count_start_select = s_q.c1[`UPC_C1_IDLE_COUNT_START_SELECT];
  assign parity_enable = s_q.c1[`UPC_C1_PEN];
  assign parity_type = s_q.c1[`UPC_C1_PTY];
  assign te = s_q.c2[`UPC_C2_TE];
  assign re = s_q.c2[`UPC_C2_RE];
  assign stby = s_q.c2[`UPC_C2_STBY];
  assign send_break = s_q.c2[`UPC_C2_SBK];

  // ====================
  // Transmit and receive engines
  logic tx_ser, tx_busy, tx_last, tx_load;
  logic [10:0] tx_frame;
  logic [3:0] tx_nbits;
  logic rx_line, rx_done, rx_ferr, rx_idle;
  logic [8:0] rx_data;

  upc_tx u_tx (
    .clk(clk),
    .nrst(nrst),
    .clr(!en), // R5
    .tick(s_q.tick),
    .load(tx_load),
    .frame(tx_frame),
    .nbits(tx_nbits),
    .ser(tx_ser),
    .busy(tx_busy),
    .last(tx_last)
  );

  // Loop mode cuts the pin off and listens to our own shifter
  assign rx_line = loop ? tx_ser : s_q.rline; // R3

  upc_rx #(
    .DIV(BIT_CYCLES)
  ) u_rx (
    .clk(clk),
    .nrst(nrst),
    .en(en && re), // R18
    .line(rx_line),
    .len(len),
    .idle_count_start_select(idle_count_start_select),
    .data(rx_data),
    .done(rx_done),
    .ferr(rx_ferr),
    .idle(rx_idle)
  );

  // ====================
  // Frame choice: break beats the trailing one, the preamble and data
  logic [8:0] tx_word;
  logic can_load, want_brk;
  always_comb begin
    tx_word = {s_q.t8, s_q.tdr};
    if (parity_enable) begin
      if (len) begin
        tx_word[8] = upc_parity(tx_word, len, parity_type); // R8
      end else begin
        tx_word[7] = upc_parity(tx_word, len, parity_type); // R8
      end
    end
    can_load = en && te && s_q.tick && (!tx_busy || tx_last); // R15
    want_brk = send_break || s_q.brk_pend;
    tx_load = 1'b0;
    tx_nbits = upc_flen(len); // R7
    tx_frame = 11'h7FF;
    if (can_load) begin
      if (want_brk) begin
        tx_load = 1'b1;
        // In short frames the unsent top bit stays one so the line rests high if no frame follows
        tx_frame = len ? 11'h000 : 11'h400; // R25
      end else if (s_q.one_pend) begin
        tx_load = 1'b1;
        tx_nbits = 4'h1; // R20
      end else if (s_q.pre_pend) begin
        tx_load = 1'b1; // R14
      end else if (!s_q.txe) begin
        tx_load = 1'b1;
        tx_frame = len ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0}; // R7
      end
    end
  end

  // ====================
  // Receive result decode
  logic rx_msb, rx_perr;
  assign rx_msb = len ? rx_data[8] : rx_data[7];
  assign rx_perr = parity_enable && (rx_msb != upc_parity(rx_data, len, parity_type)); // R8

  // ====================
  // Register file, flags and sequencing; each status flag set is applied after its clear
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.rdata = 8'h00;
    // Three-stage synchroniser; a level counts once the last two agree
    s_d.rsync = {s_q.rsync[1:0], port_pin_rx_in};
    if (s_q.rsync[1] == s_q.rsync[2]) begin
      s_d.rline = s_q.rsync[2];
    end
    // Baud generator runs only while enabled
    if (en) begin // R5
      s_d.bcnt = s_q.bcnt + 16'h0001;
      if (s_q.bcnt == 16'(BIT_CYCLES - 1)) begin
        s_d.bcnt = 16'h0000;
        s_d.tick = 1'b1;
      end
    end else begin
      s_d.bcnt = 16'h0000;
    end
    // Register reads: the status read arms the two-step clears
    if (rd) begin
      case (addr)
        `UPC_OFS_CTL1: s_d.rdata = s_q.c1;
        `UPC_OFS_CTL2: s_d.rdata = s_q.c2;
        `UPC_OFS_STAT: begin
          s_d.rdata = {s_q.txe, s_q.tc, s_q.rxf, s_q.idle, 2'b00, s_q.fe, s_q.pe};
          s_d.txe_arm = s_q.txe; // R23
          s_d.rx_arm = s_q.rxf || s_q.idle || s_q.pe || s_q.fe;
        end
        `UPC_OFS_DATA: begin
          s_d.rdata = s_q.rdr[7:0];
          if (s_q.rx_arm) begin
            s_d.rxf = 1'b0;
            s_d.idle = 1'b0;
            s_d.pe = 1'b0;
            s_d.fe = 1'b0;
            s_d.rx_arm = 1'b0;
          end
        end
        `UPC_OFS_AUX: s_d.rdata = {6'h00, s_q.rdr[8], s_q.t8};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (wr) begin
      case (addr)
        `UPC_OFS_CTL1: s_d.c1 = wdata;
        `UPC_OFS_CTL2: begin
          s_d.c2 = wdata;
          if (wdata[`UPC_C2_TE] && !te) begin
            s_d.pre_pend = 1'b1; // R14 R16
          end
          if (wdata[`UPC_C2_SBK] && !send_break) begin
            s_d.brk_pend = 1'b1; // R20
          end
        end
        `UPC_OFS_DATA: begin
          s_d.tdr = wdata;
          if (s_q.txe_arm) begin
            s_d.txe = 1'b0; // R23
            s_d.txe_arm = 1'b0;
          end
        end
        `UPC_OFS_AUX: s_d.t8 = wdata[0];
        default: begin
        end
      endcase
    end
    // Transmit sequencing
    if (tx_load) begin
      if (want_brk) begin
        s_d.brk_pend = 1'b0;
        s_d.pre_pend = 1'b0; // R21
        s_d.one_pend = 1'b1; // R20
      end else if (s_q.one_pend) begin
        s_d.one_pend = 1'b0;
      end else if (s_q.pre_pend) begin
        s_d.pre_pend = 1'b0;
      end else begin
        s_d.txe = 1'b1; // R23
      end
    end
    // Receive results
    if (rx_done) begin
      if (!stby || (wake && rx_msb)) begin // R9
        if (stby) begin
          s_d.c2[`UPC_C2_STBY] = 1'b0; // R19
        end
        if (!s_d.rxf) begin
          s_d.rdr = rx_data;
        end
        s_d.rxf = 1'b1;
        s_d.pe = s_d.pe || rx_perr;
        s_d.fe = s_d.fe || rx_ferr;
        s_d.idle_arm = 1'b1;
      end
    end
    if (rx_idle) begin
      if (stby && !wake) begin
        s_d.c2[`UPC_C2_STBY] = 1'b0; // R9 R19
      end else if (!stby && s_q.idle_arm) begin
        s_d.idle = 1'b1;
        s_d.idle_arm = 1'b0;
      end
    end
    // A disabled module reports an empty, finished transmitter
    if (!en) begin
      s_d.txe = 1'b1; // R5
      s_d.tc = 1'b1;
      s_d.pre_pend = 1'b0;
      s_d.brk_pend = 1'b0;
      s_d.one_pend = 1'b0;
    end else begin
      s_d.tc = s_d.txe && !tx_busy && !tx_load && !s_d.pre_pend && !s_d.brk_pend && !s_d.one_pend; // R24
    end
  end

  // Control registers clear on reset; the empty and complete flags start set
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.c1 <= `UPC_CTL_RST; // R22
      s_q.c2 <= `UPC_CTL_RST; // R22
      s_q.txe <= 1'b1;
      s_q.tc <= 1'b1;
      s_q.rsync <= 3'h7;
      s_q.rline <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ====================
  // Pin ownership and request lines
  assign port_pin_tx_out = en ? (tx_ser ^ inv) : port_tx_data; // R1 R6
  assign port_pin_tx_oe = en || tx_pin_direction_bit; // R1
  assign port_pin_rx_out = port_rx_data;
  assign port_pin_rx_oe = !en && rx_pin_direction_bit; // R2
  assign tx_irq = en && ((s_q.txe && s_q.c2[`UPC_C2_TEIE]) || (s_q.tc && s_q.c2[`UPC_C2_TX_DONE_IRQ_ENABLE])); // R5 R12
  assign rx_irq = !stby && ((s_q.rxf && s_q.c2[`UPC_C2_RFIE]) || (s_q.idle && s_q.c2[`UPC_C2_IDLE_LINE_IRQ_ENABLE])); // R13 R19
  assign rdata = s_q.rdata;

  // ====================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  tx_pin_owned_a: assert property (en |-> port_pin_tx_oe && port_pin_tx_out == (tx_ser ^ inv)) // R1
    else $error("transmit pin not owned while enabled");
  rx_pin_owned_a: assert property (en && rx_pin_direction_bit |-> !port_pin_rx_oe) // R2
    else $error("receive pin driven while enabled");
  loop_feed_a: assert property (loop |-> rx_line == tx_ser) // R3
    else $error("loop path not fed from transmitter");
  disable_flags_a: assert property ($fell(en) |-> ##1 s_q.txe && s_q.tc && !tx_irq) // R5
    else $error("disable did not set transmit flags");
  idle_level_a: assert property (en && !te && !tx_busy |-> port_pin_tx_out == !inv) // R6 R15
    else $error("idle level wrong");
  tc_needs_txe_a: assert property (s_q.tc |-> s_q.txe) // R24
    else $error("complete set without empty");
  tx_req_gate_a: assert property (tx_irq |-> (s_q.c2[`UPC_C2_TEIE] && s_q.txe) || (s_q.c2[`UPC_C2_TX_DONE_IRQ_ENABLE] && s_q.tc)) // R12
    else $error("transmit request without enabled flag");
  standby_quiet_a: assert property (stby |-> !rx_irq) // R19
    else $error("receive request during standby");
  reset_ctl_a: assert property (@(posedge clk) disable iff (1'b0) !nrst |=> s_q.c1 == 8'h00 && s_q.c2 == 8'h00) // R22
    else $error("control registers not cleared by reset");
  break_zero_a: assert property (tx_load && want_brk |=> tx_busy && !tx_ser) // R25
    else $error("break frame not zero");
  preamble_first_a: assert property (wr && addr == `UPC_OFS_CTL2 && wdata[`UPC_C2_TE] && !te && en |=> s_q.pre_pend || s_q.brk_pend || send_break) // R14
    else $error("preamble not queued on transmitter enable");
endmodule : upc_top

// >>> bench/upc_peer.sv
// Remote serial node model: sends frames to the receive pin and captures frames from the transmit pin
module upc_peer #(
  parameter int BC = 4
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles at the mark level between frames
  initial line_out = 1'b1;

  // Shift a frame out LSB first, one bit per BC clocks
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BC) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : send

  // Wait for a start edge, then sample mid-bit on falling edges, clear of the launching edge
  task automatic recv(input int n, output logic [10:0] f, output int t);
    f = '0;
    for (t = 0; t < 2000 && line_in !== 1'b0; t++) @(negedge clk);
    repeat (BC / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in;
      repeat (BC) @(negedge clk);
    end
  endtask : recv
endmodule : upc_peer

// >>> bench/upc_top_tb.sv
// Self-checking bench of the serial control block
module upc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import upc_pkg::*;
  localparam int BC = 4;
  logic clk, nrst, wr, rd, ptx, prx, dtx, drx, rx_in, peer_out, line_ok;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v;
  logic tx_out, tx_oe, rx_out, rx_oe, tx_irq, rx_irq;
  logic [10:0] f;
  int n_fail, n_tests, t;
  typedef struct {logic [7:0] c1; logic [7:0] aux; logic [7:0] d; logic [10:0] fr;} upc_row_s;
  upc_row_s rows [4] = '{'{8'h40, 8'h00, 8'h5A, 11'h2B4}, '{8'h42, 8'h00, 8'hB5, 11'h26A},
                         '{8'h43, 8'h00, 8'h35, 11'h36A}, '{8'h50, 8'h01, 8'h00, 11'h600}};

  upc_top #(.BIT_CYCLES(BC)) upc_top_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .port_tx_data(ptx), .port_rx_data(prx), .tx_pin_direction_bit(dtx),
    .rx_pin_direction_bit(drx), .port_pin_tx_out(tx_out), .port_pin_tx_oe(tx_oe), .port_pin_rx_in(rx_in),
    .port_pin_rx_out(rx_out), .port_pin_rx_oe(rx_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  upc_peer #(.BC(BC)) upc_peer_inst (.clk(clk), .line_in(tx_out), .line_out(peer_out));
  // The bench can hold the receive wire low to show it is cut off in loop mode
  assign rx_in = peer_out & line_ok;

  // ====================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // ====================
  // Bus cycles and compares
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_frame(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_frame
  // Poll a status bit with a bound; running out ends the run
  task automatic wait_st(input int b);
    for (int i = 0; i < 300; i++) begin
      rd_reg(3'h2, v);
      if (v[b] === 1'b1) return;
    end
    n_fail++;
    $display("BAD status wait bit %0d", b);
    print_verdict();
  endtask : wait_st
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ====================
  // Main sequence
  initial begin
    {nrst, wr, rd, addr, wdata, prx, drx, dtx} = '0;
    {ptx, line_ok} = 2'b11;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and register readback, unmapped places read zero
    rd_reg(3'h0, v); chk_byte("ctl1 rst", 8'h00, v);
    rd_reg(3'h1, v); chk_byte("ctl2 rst", 8'h00, v);
    rd_reg(3'h2, v); chk_byte("stat rst", 8'hC0, v);
    wr_reg(3'h0, 8'h3D); rd_reg(3'h0, v); chk_byte("ctl1 rw", 8'h3D, v);
    wr_reg(3'h5, 8'hFF); rd_reg(3'h5, v); chk_byte("unmapped", 8'h00, v);
    wr_reg(3'h0, 8'h00);
    $display("test registers done");
    // Pin ownership: port logic while disabled, serial module once enabled
    dtx <= 1'b0; drx <= 1'b1; ptx <= 1'b0; prx <= 1'b1;
    @(posedge clk); #1;
    chk_byte("tx oe off", 8'h00, {7'h00, tx_oe});
    chk_byte("tx out off", 8'h00, {7'h00, tx_out});
    chk_byte("rx oe off", 8'h01, {7'h00, rx_oe});
    chk_byte("rx out off", 8'h01, {7'h00, rx_out});
    wr_reg(3'h0, 8'h40); ptx <= 1'b1; #1;
    chk_byte("tx oe on", 8'h01, {7'h00, tx_oe});
    chk_byte("rx oe on", 8'h00, {7'h00, rx_oe});
    $display("test pins done");
    // Frame table: preamble first, then length, parity and ninth bit
    wr_reg(3'h1, 8'h08);
    foreach (rows[i]) begin
      wr_reg(3'h0, rows[i].c1);
      wr_reg(3'h4, rows[i].aux);
      rd_reg(3'h2, v);
      wr_reg(3'h3, rows[i].d);
      upc_peer_inst.recv(rows[i].c1[4] ? 11 : 10, f, t);
      chk_frame("tx frame", rows[i].fr, f);
      if (i == 0) chk_byte("preamble", 8'h01, {7'h00, t >= 7 * BC});
    end
    $display("test transmit done");
    // Reception with its request raised by the full flag and cleared by the data read
    wr_reg(3'h0, 8'h40); wr_reg(3'h1, 8'h2C);
    upc_peer_inst.send(11'h34A, 10);
    wait_st(5);
    chk_byte("rx irq on", 8'h01, {7'h00, rx_irq});
    rd_reg(3'h3, v); chk_byte("rx data", 8'hA5, v);
    @(posedge clk); #1 chk_byte("rx irq off", 8'h00, {7'h00, rx_irq});
    // Address mark ends standby
    wr_reg(3'h0, 8'h48); wr_reg(3'h1, 8'h2E);
    upc_peer_inst.send(11'h30A, 10);
    wait_st(5);
    rd_reg(3'h1, v); chk_byte("standby off", 8'h2C, v);
    rd_reg(3'h3, v); chk_byte("mark data", 8'h85, v);
    $display("test receive done");
    // Loop mode with the receive wire held low
    line_ok <= 1'b0;
    wr_reg(3'h0, 8'hC0); wr_reg(3'h1, 8'h0C);
    rd_reg(3'h2, v); wr_reg(3'h3, 8'h3C);
    wait_st(5);
    rd_reg(3'h3, v); chk_byte("loop data", 8'h3C, v);
    wr_reg(3'h0, 8'h40); line_ok <= 1'b1;
    $display("test loop done");
    // Held break repeats with no ones between; release ends it
    wr_reg(3'h1, 8'h09);
    for (t = 0; t < 200 && tx_out !== 1'b0; t++) @(posedge clk);
    v = 8'h00;
    repeat (100) begin
      @(posedge clk);
      if (tx_out === 1'b0) v++;
    end
    chk_byte("break low", 8'h64, v);
    wr_reg(3'h1, 8'h08);
    for (t = 0; t < 60 && tx_out !== 1'b1; t++) @(posedge clk);
    chk_byte("break end", 8'h01, {7'h00, t < 60});
    repeat (12 * BC) @(posedge clk);
    $display("test break done");
    // Transmit requests gated by their enables and by module enable
    wr_reg(3'h1, 8'h80); #1 chk_byte("empty irq", 8'h01, {7'h00, tx_irq});
    wr_reg(3'h1, 8'h00); #1 chk_byte("irq masked", 8'h00, {7'h00, tx_irq});
    wr_reg(3'h1, 8'h40); #1 chk_byte("done irq", 8'h01, {7'h00, tx_irq});
    wr_reg(3'h0, 8'h00); #1 chk_byte("irq off", 8'h00, {7'h00, tx_irq});
    rd_reg(3'h2, v); chk_byte("flags set", 8'hC0, v & 8'hC0);
    // Inverted idle level
    wr_reg(3'h0, 8'h60); repeat (2) @(posedge clk); #1;
    chk_byte("inv idle", 8'h00, {7'h00, tx_out});
    $display("test irq and polarity done");
    // Second reset in mid-run clears control again
    @(posedge clk);
    nrst <= 1'b0; repeat (2) @(posedge clk); nrst <= 1'b1;
    rd_reg(3'h0, v); chk_byte("ctl1 rerst", 8'h00, v);
    rd_reg(3'h2, v); chk_byte("stat rerst", 8'hC0, v);
    rd_reg(3'h1, v); chk_byte("ctl2 rerst", 8'h00, v);
    $display("test reset done");
    print_verdict();
  end
endmodule : upc_top_tb
